// File: common/adq_map.svh
`ifndef ADQ_MAP_SVH
`define ADQ_MAP_SVH
// ---------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ---------------------------------------------------------------------
`define ADQ_IDX_SCAN_SEL    8'hCA
`define ADQ_IDX_SCAN_PEND   8'hCB
`define ADQ_IDX_SCAN_MODE   8'hCC
`define ADQ_IDX_QUEUE_CTRL  8'hCD
`define ADQ_IDX_QUEUE_STATE 8'hCE
`define ADQ_IDX_QUEUE_IN    8'hD0
`define ADQ_IDX_QUEUE_HEAD  8'hD1
`define ADQ_IDX_BACKUP      8'hD2
`define ADQ_IDX_TRIG_SEL    8'hD3
`define ADQ_IDX_ARB_SLOT    8'hD4
`define ADQ_IDX_EVENT       8'hD5
// ---------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------
`define ADQ_B_GATE      0
`define ADQ_B_HWTRIG    2
`define ADQ_B_SIRQ      3
`define ADQ_B_AUTOSCAN  4
`define ADQ_B_CLRPEND   5
`define ADQ_B_LOAD      6
`define ADQ_B_DROP      4
`define ADQ_B_FLUSH     5
`define ADQ_B_SWTRIG    6
`define ADQ_B_EVCLR     7
`define ADQ_B_EMPTY     5
`define ADQ_B_EVFLAG    4
`define ADQ_B_REFILL    4
`define ADQ_B_ENT_IRQ   5
`define ADQ_B_EXTWAIT   6
`define ADQ_B_VALID     7
`define ADQ_B_SLOT_Q    0
`define ADQ_B_SLOT_S    1
`define ADQ_B_EV_Q      0
`define ADQ_B_EV_S      1
// ---------------------------------------------------------------------
// Sizes and reset values
// ---------------------------------------------------------------------
`define ADQ_STAGES      3'd4
`define ADQ_CHAN_MASK   8'hFF
`define ADQ_RST_QSTATE  8'h20
`define ADQ_RST_BYTE    8'h00
`endif

// File: common/adq_pkg.sv
package adq_pkg;
  // Queue entry as held in each stage and in the backup stage
  typedef struct packed {
    logic       ext_wait;
    logic       irq_on;
    logic       refill;
    logic [2:0] chan;
  } adq_entry_type;

  // Bus slave phase
  typedef enum logic [0:0] {
    ADQ_BUS_IDLE,
    ADQ_BUS_RD
  } adq_bus_type;
endpackage

// File: core/adq_top.sv
`timescale 1ns/1ps
`include "adq_map.svh"

// Behaviour
// - Pending bit cleared at start, set at abort
// - Pending write goes to select, load next cycle
// - Software writes alter pending bits only via load or clear-pending
// - Channels above variant count read zero
// - Queue is FIFO, stage 0 converts next
// - Queue requests only with valid stage 0 or valid backup
// - Aborted entry saved in backup, served first
// - Trigger flag cleared by start or clear-event
// - Trigger from selected hardware input or software
// - Entry holds channel, wait, irq, refill options
// - Start moves stage 0 into backup, advances
// - Stages change only via input, start, drop-next or flush
// - Refill entries reload into queue after start
// - Queue holds four stages
// - Write into empty queue requests without trigger unless wait is set
// - Write to full queue is discarded
// - Drop-next clears backup else stage 0
// - Flush empties all queue stages
// - Slot disable gates requests, keeps entries
// - Gate bit turns source off or on
// - Hardware edge sets flag if entry valid
// - Completion sets event, pulses service request
module adq_top
  import adq_pkg::*;
(
  input  wire logic        clk,          // System clock
  input  wire logic        rst_n,        // Async reset, active low
  input  wire logic        hsel,         // Slave select
  input  wire logic [31:0] haddr,        // Byte address
  input  wire logic [1:0]  htrans,       // Transfer type
  input  wire logic        hwrite,       // Write access
  input  wire logic [2:0]  hsize,        // Transfer size
  input  wire logic [31:0] hwdata,       // Write data
  input  wire logic        hready,       // Bus ready
  output logic             hreadyout,    // Slave ready
  output logic [31:0]      hrdata,       // Read data
  output logic             hresp,        // Always OKAY
  input  wire logic [7:0]  ext_trigger_input, // Hardware trigger lines
  input  wire logic        q_start,      // Arbiter starts queued conversion
  input  wire logic        q_abort,      // Arbiter aborts queued conversion
  input  wire logic        q_done,       // Queued conversion finished
  output logic             q_req,        // Queued source requests
  output logic [2:0]       q_chan,       // Channel of queued request
  input  wire logic        scan_start,   // Arbiter starts scan conversion
  input  wire logic        scan_abort,   // Arbiter aborts scan conversion
  input  wire logic        scan_done,    // Scan conversion finished
  input  wire logic [2:0]  scan_chan,    // Channel of scan start/abort
  output logic             scan_req,     // Scan source requests
  output logic [7:0]       scan_pend,    // Pending channels to arbiter
  output logic             q_service_req,    // Queue service request pulse
  output logic             scan_service_req  // Scan service request pulse
);

  // -------------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_s_n;

  // Two-stage release of the reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_s_n = rst_sync_r[1];

  // -------------------------------------------------------------------
  // Register state
  // -------------------------------------------------------------------
  logic [7:0]    sel_r;          // scan_channel_select_reg
  logic [7:0]    pend_r;         // channel_pending_bit vector
  logic [4:0]    smode_r;        // scan mode rw bits
  logic [2:0]    qmode_r;        // queue mode rw bits
  logic [7:0]    tsel_r;         // trigger_select_reg
  logic [1:0]    slot_r;         // arbitration_slot_reg
  logic [1:0]    evf_r;          // source event indication
  logic          load_r;         // delayed load event
  logic          trig_q_d_r;     // previous queue trigger level
  logic          trig_s_d_r;     // previous scan trigger level
  adq_entry_type q_r [4];        // queue stages, index 0 is head
  logic [2:0]    cnt_r;          // number of filled stages
  adq_entry_type bkp_r;          // backup_stage_reg / running entry
  logic          bkp_v_r;        // backup stage valid
  logic          ev_r;           // trigger_occurred_flag

  // -------------------------------------------------------------------
  // AHB-Lite slave
  // -------------------------------------------------------------------
  adq_bus_type bus_r;
  logic        wr_r;
  logic [7:0]  widx_r;
  logic [7:0]  ridx_r;
  logic        take;
  logic        wr_act;
  logic [7:0]  wb;

  assign take   = hsel && hready && htrans[1];
  assign wr_act = wr_r;
  assign wb     = hwdata[7:0];

  // Register one access; reads add one wait state so writes land first
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      bus_r     <= ADQ_BUS_IDLE;
      wr_r      <= 1'b0;
      widx_r    <= 8'h00;
      ridx_r    <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      wr_r <= take && hwrite;
      if (take) begin
        widx_r <= haddr[9:2];
        ridx_r <= haddr[9:2];
      end
      unique case (bus_r)
        ADQ_BUS_IDLE: begin
          if (take && !hwrite) begin
            bus_r     <= ADQ_BUS_RD;
            hreadyout <= 1'b0;
          end
        end
        ADQ_BUS_RD: begin
          bus_r     <= ADQ_BUS_IDLE;
          hreadyout <= 1'b1;
          hrdata    <= {24'h00_0000, rd_mux(ridx_r)};
        end
      endcase
    end
  end

  function automatic logic wr_hit(input logic [7:0] idx);
    wr_hit = wr_act && (widx_r == idx);
  endfunction

  function automatic logic [7:0] ent_byte(input adq_entry_type e, input logic v);
    ent_byte = {v, e.ext_wait, e.irq_on, e.refill, 1'b0, e.chan};
  endfunction

  // Read view of every register; unmapped reads as zero
  function automatic logic [7:0] rd_mux(input logic [7:0] idx);
    logic [7:0] r;
    r = 8'h00;
    unique case (idx)
      `ADQ_IDX_SCAN_SEL:    r = sel_r & `ADQ_CHAN_MASK;
      `ADQ_IDX_SCAN_PEND:   r = pend_r & `ADQ_CHAN_MASK;
      `ADQ_IDX_SCAN_MODE:   r = {3'b000, smode_r[4:2], 1'b0, smode_r[0]};
      `ADQ_IDX_QUEUE_CTRL:  r = {5'b00000, qmode_r[2], 1'b0, qmode_r[0]};
      `ADQ_IDX_QUEUE_STATE: begin
        r[`ADQ_B_EMPTY]  = (cnt_r == 3'd0);
        r[`ADQ_B_EVFLAG] = ev_r;
        r[1:0]           = (cnt_r == 3'd0) ? 2'd0 : 2'(cnt_r - 3'd1);
      end
      `ADQ_IDX_QUEUE_HEAD:  r = ent_byte(q_r[0], cnt_r != 3'd0);
      `ADQ_IDX_BACKUP:      r = ent_byte(bkp_r, bkp_v_r);
      `ADQ_IDX_TRIG_SEL:    r = tsel_r;
      `ADQ_IDX_ARB_SLOT:    r = {6'b00_0000, slot_r};
      `ADQ_IDX_EVENT:       r = {6'b00_0000, evf_r};
      default:              r = 8'h00;
    endcase
    rd_mux = r;
  endfunction

  // -------------------------------------------------------------------
  // Configuration registers
  // -------------------------------------------------------------------
  logic wr_ctrl;
  logic wr_mode;

  always_comb wr_ctrl = wr_hit(`ADQ_IDX_QUEUE_CTRL); // Process form tracks decode state
  always_comb wr_mode = wr_hit(`ADQ_IDX_SCAN_MODE);

  // Plain read/write configuration bits
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      smode_r <= 5'b00000;
      qmode_r <= 3'b000;
      tsel_r  <= `ADQ_RST_BYTE;
      slot_r  <= 2'b00;
    end else begin
      if (wr_mode) begin
        smode_r <= {wb[4:2], 1'b0, wb[0]};
      end
      if (wr_ctrl) begin
        qmode_r <= {wb[2], 1'b0, wb[0]};
      end
      if (wr_hit(`ADQ_IDX_TRIG_SEL)) begin
        tsel_r <= wb;
      end
      if (wr_hit(`ADQ_IDX_ARB_SLOT)) begin
        slot_r <= wb[1:0];
      end
    end
  end

  // -------------------------------------------------------------------
  // Trigger edges
  // -------------------------------------------------------------------
  logic trig_q;
  logic trig_s;
  logic edge_q;
  logic edge_s;

  assign trig_q = ext_trigger_input[tsel_r[2:0]];
  assign trig_s = ext_trigger_input[tsel_r[6:4]];
  assign edge_q = trig_q && !trig_q_d_r;
  assign edge_s = trig_s && !trig_s_d_r;

  // Previous trigger levels for edge detection
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      trig_q_d_r <= 1'b0;
      trig_s_d_r <= 1'b0;
    end else begin
      trig_q_d_r <= trig_q;
      trig_s_d_r <= trig_s;
    end
  end

  // -------------------------------------------------------------------
  // Scan source
  // -------------------------------------------------------------------
  logic       scan_last;
  logic [7:0] pend_nxt;

  assign scan_last = scan_done && (pend_r == 8'h00);

  // Select register takes writes to either address
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      sel_r  <= `ADQ_RST_BYTE;
      load_r <= 1'b0;
    end else begin
      if (wr_hit(`ADQ_IDX_SCAN_SEL) || wr_hit(`ADQ_IDX_SCAN_PEND)) begin
        sel_r <= wb & `ADQ_CHAN_MASK;
      end
      load_r <= wr_hit(`ADQ_IDX_SCAN_PEND)
             || (wr_mode && wb[`ADQ_B_LOAD])
             || (smode_r[`ADQ_B_HWTRIG] && edge_s)
             || (smode_r[`ADQ_B_AUTOSCAN] && scan_last);
    end
  end

  // Pending bits change only by load, start, abort and clear
  always_comb begin
    pend_nxt = pend_r;
    if (scan_start) begin
      pend_nxt[scan_chan] = 1'b0;
    end
    if (scan_abort) begin
      pend_nxt[scan_chan] = 1'b1;
    end
    if (load_r) begin
      pend_nxt = sel_r;
    end
    if (wr_mode && wb[`ADQ_B_CLRPEND]) begin
      pend_nxt = 8'h00;
    end
    pend_nxt = pend_nxt & `ADQ_CHAN_MASK;
  end

  // Pending register and scan request
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      pend_r           <= `ADQ_RST_BYTE;
      scan_pend        <= 8'h00;
      scan_req         <= 1'b0;
      scan_service_req <= 1'b0;
    end else begin
      pend_r           <= pend_nxt;
      scan_pend        <= pend_nxt;
      scan_req         <= slot_r[`ADQ_B_SLOT_S] && smode_r[`ADQ_B_GATE]
                          && (pend_nxt != 8'h00);
      scan_service_req <= scan_last && smode_r[`ADQ_B_SIRQ];
    end
  end

  // -------------------------------------------------------------------
  // Queued source
  // -------------------------------------------------------------------
  adq_entry_type q_nxt [4];
  adq_entry_type in_ent;
  logic [2:0]    cnt_nxt;
  logic          head_v;
  logic          from_bkp;
  logic          start_head;
  logic          drop_cmd;
  logic          pop;
  logic          push;
  logic          refill_push;
  logic          bkp_v_nxt;
  logic          ev_nxt;
  logic          gate_q;

  assign head_v      = (cnt_r != 3'd0);
  assign from_bkp    = bkp_v_r;
  assign start_head  = q_start && !from_bkp && head_v;
  assign drop_cmd    = wr_ctrl && wb[`ADQ_B_DROP];
  assign pop         = start_head || (drop_cmd && !bkp_v_r && head_v);
  assign refill_push = start_head && q_r[0].refill;
  always_comb push   = refill_push || wr_hit(`ADQ_IDX_QUEUE_IN);
  assign gate_q      = qmode_r[`ADQ_B_GATE];
  assign in_ent      = refill_push ? q_r[0] :
                       '{ext_wait: wb[`ADQ_B_EXTWAIT], irq_on: wb[`ADQ_B_ENT_IRQ],
                         refill: wb[`ADQ_B_REFILL], chan: wb[2:0]};

  // Next contents of the four-stage FIFO
  always_comb begin
    q_nxt   = q_r;
    cnt_nxt = cnt_r;
    if (pop) begin
      for (int i = 0; i < 3; i++) begin
        q_nxt[i] = q_r[i + 1];
      end
      cnt_nxt = cnt_r - 3'd1;
    end
    if (push && (cnt_nxt < `ADQ_STAGES)) begin
      q_nxt[cnt_nxt[1:0]] = in_ent;
      cnt_nxt = cnt_nxt + 3'd1;
    end
    if (wr_ctrl && wb[`ADQ_B_FLUSH]) begin
      cnt_nxt = 3'd0;
    end
  end

  // Backup valid and trigger flag next values
  always_comb begin
    bkp_v_nxt = bkp_v_r;
    if (q_start && from_bkp) begin
      bkp_v_nxt = 1'b0;
    end
    if (drop_cmd && bkp_v_r) begin
      bkp_v_nxt = 1'b0;
    end
    if (q_abort) begin
      bkp_v_nxt = 1'b1;
    end
    ev_nxt = ev_r;
    if (q_start || (wr_ctrl && wb[`ADQ_B_EVCLR])) begin
      ev_nxt = 1'b0;
    end
    if ((wr_ctrl && wb[`ADQ_B_SWTRIG])
        || (qmode_r[`ADQ_B_HWTRIG] && edge_q && (head_v || bkp_v_r))) begin
      ev_nxt = 1'b1;
    end
  end

  // Queue stages, backup stage and trigger flag
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      for (int i = 0; i < 4; i++) begin
        q_r[i] <= '0;
      end
      cnt_r   <= 3'd0;
      bkp_r   <= '0;
      bkp_v_r <= 1'b0;
      ev_r    <= 1'b0;
    end else begin
      q_r     <= q_nxt;
      cnt_r   <= cnt_nxt;
      bkp_v_r <= bkp_v_nxt;
      ev_r    <= ev_nxt;
      if (start_head) begin
        bkp_r <= q_r[0];
      end
    end
  end

  // Request to the arbiter, computed from next state
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      q_req  <= 1'b0;
      q_chan <= 3'd0;
    end else begin
      q_req  <= slot_r[`ADQ_B_SLOT_Q] && gate_q
                && (bkp_v_nxt
                    || ((cnt_nxt != 3'd0)
                        && (!q_nxt[0].ext_wait || ev_nxt)));
      q_chan <= bkp_v_nxt ? (start_head ? q_r[0].chan : bkp_r.chan) : q_nxt[0].chan;
    end
  end

  // -------------------------------------------------------------------
  // Source events
  // -------------------------------------------------------------------
  // Event flags: hardware set wins over write-one clear
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      evf_r         <= 2'b00;
      q_service_req <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_hit(`ADQ_IDX_EVENT) && wb[i]) begin
          evf_r[i] <= 1'b0;
        end
      end
      if (q_done) begin
        evf_r[`ADQ_B_EV_Q] <= 1'b1;
      end
      if (scan_last) begin
        evf_r[`ADQ_B_EV_S] <= 1'b1;
      end
      q_service_req <= q_done && bkp_r.irq_on;
    end
  end

endmodule

// File: verif/adq_arb_model.sv
`timescale 1ns/1ps
// -------------
// Arbiter model
// -------------
module adq_arb_model (
  input  wire logic       clk,        // Clock
  input  wire logic       rst_n,      // Reset
  input  wire logic       en,         // Accept requests
  input  wire logic [3:0] lat,        // Conversion length
  input  wire logic       abort_nxt,  // End by abort
  input  wire logic       q_req,      // Queue request
  input  wire logic       scan_req,   // Scan request
  input  wire logic [7:0] scan_pend,  // Scan pending bits
  output logic            q_start,    // Queue start pulse
  output logic            q_abort,    // Queue abort pulse
  output logic            q_done,     // Queue done pulse
  output logic            scan_start, // Scan start pulse
  output logic            scan_abort, // Scan abort pulse
  output logic            scan_done,  // Scan done pulse
  output logic [2:0]      scan_chan   // Scan channel
);
  logic [4:0] cnt_r;
  logic       isq_r;

  // One conversion at a time, a gap cycle after each end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
      isq_r <= 1'b0;
      scan_chan <= 3'h0;
      {q_start, q_abort, q_done} <= 3'h0;
      {scan_start, scan_abort, scan_done} <= 3'h0;
    end else begin
      {q_start, q_abort, q_done} <= 3'h0;
      {scan_start, scan_abort, scan_done} <= 3'h0;
      if (cnt_r != 5'h00) begin
        cnt_r <= cnt_r - 5'h01;
      end else if (en && (q_req || scan_req)) begin
        cnt_r <= {1'b0, lat} + 5'h02;
        isq_r <= q_req;
        q_start <= q_req;
        scan_start <= !q_req;
        for (int i = 7; i >= 0; i--) begin
          if (scan_pend[i] && !q_req) begin
            scan_chan <= 3'(i);
          end
        end
      end
      if (cnt_r == 5'h02) begin
        {q_abort, scan_abort} <= abort_nxt ? {isq_r, !isq_r} : 2'h0;
        {q_done, scan_done} <= abort_nxt ? 2'h0 : {isq_r, !isq_r};
      end
    end
  end
endmodule

// File: verif/adq_properties.sv
`timescale 1ns/1ps
// -------
// Checker
// -------
module adq_checker (
  input wire logic        clk,           // Clock
  input wire logic        rst_n,         // Reset
  input wire logic        hsel,          // Select
  input wire logic [1:0]  htrans,        // Transfer type
  input wire logic        hwrite,        // Write
  input wire logic        hready,        // Bus ready
  input wire logic        hreadyout,     // Slave ready
  input wire logic [31:0] hrdata,        // Read data
  input wire logic        hresp,         // Response
  input wire logic        q_start,       // Queue start
  input wire logic        q_abort,       // Queue abort
  input wire logic        q_done,        // Queue done
  input wire logic        q_req,         // Queue request
  input wire logic [2:0]  q_chan,        // Queue channel
  input wire logic        q_service_req, // Queue service
  input wire logic        scan_start,    // Scan start
  input wire logic        scan_abort,    // Scan abort
  input wire logic [2:0]  scan_chan,     // Scan channel
  input wire logic        scan_req,      // Scan request
  input wire logic [7:0]  scan_pend      // Pending bits
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic       taken;
  logic       act;
  logic [2:0] hist_r;

  // Transfer taken and queue activity
  assign taken = hsel && hready && htrans[1];
  assign act = q_start || q_abort || taken;

  // Recent activity history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hist_r <= 3'h7;
    end else begin
      hist_r <= {hist_r[1:0], act};
    end
  end

  a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("upper read data set");
  a_pend_start: assert property (scan_start |-> ##[1:2] !scan_pend[scan_chan])
    else $error("pending kept at start");
  a_pend_abort: assert property (scan_abort |-> ##[1:2] scan_pend[scan_chan])
    else $error("pending lost at abort");
  a_scan_cause: assert property (scan_req |-> scan_pend != 8'h00)
    else $error("scan request without pending");
  a_svc_cause: assert property (q_service_req |-> $past(q_done))
    else $error("service without completion");
  a_svc_pulse: assert property (q_service_req |=> !q_service_req)
    else $error("service longer than a pulse");
  a_chan_still: assert property (q_req && !act && hist_r == 3'h0 |=> $stable(q_chan))
    else $error("queue channel changed alone");
endmodule

bind adq_top adq_checker u_chk (
  .clk(clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .q_start(q_start), .q_abort(q_abort), .q_done(q_done), .q_req(q_req),
  .q_chan(q_chan), .q_service_req(q_service_req), .scan_start(scan_start),
  .scan_abort(scan_abort), .scan_chan(scan_chan), .scan_req(scan_req),
  .scan_pend(scan_pend));

// File: verif/tb_top.sv
`timescale 1ns/1ps
`include "adq_map.svh"
// ---------
// Testbench
// ---------
module tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [7:0]  trig = 8'h00;
  logic        en = 1'b0;
  logic        abort_nxt = 1'b0;
  logic [3:0]  lat = 4'h2;
  logic        hreadyout, hresp, q_req, q_start, q_abort, q_done, q_svc, s_svc;
  logic        scan_req, scan_start, scan_abort, scan_done;
  logic [31:0] hrdata;
  logic [2:0]  q_chan, scan_chan;
  logic [7:0]  scan_pend, rd;
  logic [2:0]  seen[$];
  int          n_errors = 0, n_checks = 0, cyc = 0, n_svc = 0, n_done = 0;
  int          ns0, nd0;

  // Design and arbiter
  adq_top u_dut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .ext_trigger_input(trig), .q_start(q_start), .q_abort(q_abort),
    .q_done(q_done), .q_req(q_req), .q_chan(q_chan), .scan_start(scan_start),
    .scan_abort(scan_abort), .scan_done(scan_done), .scan_chan(scan_chan),
    .scan_req(scan_req), .scan_pend(scan_pend), .q_service_req(q_svc),
    .scan_service_req(s_svc));
  adq_arb_model u_arb (
    .clk(clk), .rst_n(rst_n), .en(en), .lat(lat), .abort_nxt(abort_nxt),
    .q_req(q_req), .scan_req(scan_req), .scan_pend(scan_pend),
    .q_start(q_start), .q_abort(q_abort), .q_done(q_done),
    .scan_start(scan_start), .scan_abort(scan_abort), .scan_done(scan_done),
    .scan_chan(scan_chan));

  // Clock
  always #5 clk = ~clk;

  // Start log, event counts and timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (q_start === 1'b1) seen.push_back(q_chan);
    if (q_svc === 1'b1 || s_svc === 1'b1) n_svc++;
    if (q_done === 1'b1) n_done++;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  // Verdict
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Single bus transfer
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {22'h00_0000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask

  // Bus helpers and compare
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    chk(what, exp, rd);
  endtask
  task automatic chk_seen(input logic [11:0] exp, input int n);
    chk("starts", 8'(n), 8'(seen.size()));
    for (int i = 0; i < n; i++) chk("start chan", {5'h00, exp[11-3*i -: 3]}, {5'h00, seen[i]});
  endtask

  // Scenarios
  task automatic t_pend();
    rchk("pend", `ADQ_IDX_SCAN_PEND, 8'h00);
    rchk("qstate", `ADQ_IDX_QUEUE_STATE, 8'h20);
    wr(8'h10, 8'hFF);
    rchk("unmapped", 8'h10, 8'h00);
    wr(`ADQ_IDX_SCAN_PEND, 8'hA5);
    rchk("select", `ADQ_IDX_SCAN_SEL, 8'hA5);
    rchk("pend", `ADQ_IDX_SCAN_PEND, 8'hA5);
    wr(`ADQ_IDX_SCAN_SEL, 8'h0F);
    rchk("pend", `ADQ_IDX_SCAN_PEND, 8'hA5);
    $display("test pend done");
  endtask
  task automatic t_scan();
    wr(`ADQ_IDX_ARB_SLOT, 8'h02);
    wr(`ADQ_IDX_SCAN_MODE, 8'h09);
    abort_nxt <= 1'b1;
    en <= 1'b1;
    idle(8);
    en <= 1'b0;
    idle(12);
    chk("pend abort", 8'hA5, scan_pend);
    abort_nxt <= 1'b0;
    en <= 1'b1;
    idle(60);
    en <= 1'b0;
    idle(8);
    rchk("pend", `ADQ_IDX_SCAN_PEND, 8'h00);
    chk("scan service", 8'h01, 8'(n_svc));
    rchk("event", `ADQ_IDX_EVENT, 8'h02);
    $display("test scan done");
  endtask

  task automatic t_queue();
    wr(`ADQ_IDX_ARB_SLOT, 8'h03);
    for (int i = 1; i <= 5; i++) wr(`ADQ_IDX_QUEUE_IN, 8'(i));
    rchk("qstate", `ADQ_IDX_QUEUE_STATE, 8'h03);
    rchk("head", `ADQ_IDX_QUEUE_HEAD, 8'h81);
    chk("gate off", 8'h00, {7'h00, q_req});
    wr(`ADQ_IDX_QUEUE_CTRL, 8'h01);
    idle(2);
    chk("request", 8'h81, {q_req, 4'h0, q_chan});
    seen.delete();
    en <= 1'b1;
    idle(40);
    en <= 1'b0;
    idle(8);
    chk_seen({3'h1, 3'h2, 3'h3, 3'h4}, 4);
    rchk("backup", `ADQ_IDX_BACKUP, 8'h04);
    rchk("qstate", `ADQ_IDX_QUEUE_STATE, 8'h20);
    $display("test queue done");
  endtask

  task automatic t_cmd();
    wr(`ADQ_IDX_QUEUE_IN, 8'h06);
    wr(`ADQ_IDX_QUEUE_IN, 8'h07);
    wr(`ADQ_IDX_QUEUE_CTRL, 8'h11);
    rchk("backup", `ADQ_IDX_BACKUP, 8'h04);
    rchk("head", `ADQ_IDX_QUEUE_HEAD, 8'h87);
    wr(`ADQ_IDX_QUEUE_HEAD, 8'h00);
    rchk("head", `ADQ_IDX_QUEUE_HEAD, 8'h87);
    wr(`ADQ_IDX_QUEUE_CTRL, 8'h11);
    rchk("qstate", `ADQ_IDX_QUEUE_STATE, 8'h20);
    wr(`ADQ_IDX_QUEUE_IN, 8'h05);
    wr(`ADQ_IDX_QUEUE_CTRL, 8'h21);
    rchk("qstate", `ADQ_IDX_QUEUE_STATE, 8'h20);
    $display("test cmd done");
  endtask

  task automatic t_trig();
    wr(`ADQ_IDX_QUEUE_IN, 8'h42);
    idle(2);
    chk("wait", 8'h00, {7'h00, q_req});
    wr(`ADQ_IDX_QUEUE_CTRL, 8'h41);
    rchk("qstate", `ADQ_IDX_QUEUE_STATE, 8'h10);
    chk("triggered", 8'h01, {7'h00, q_req});
    wr(`ADQ_IDX_QUEUE_CTRL, 8'h81);
    rchk("qstate", `ADQ_IDX_QUEUE_STATE, 8'h00);
    wr(`ADQ_IDX_TRIG_SEL, 8'h03);
    wr(`ADQ_IDX_QUEUE_CTRL, 8'h05);
    trig <= 8'h04;
    idle(3);
    rchk("qstate", `ADQ_IDX_QUEUE_STATE, 8'h00);
    trig <= 8'h0C;
    idle(3);
    rchk("qstate", `ADQ_IDX_QUEUE_STATE, 8'h10);
    en <= 1'b1;
    idle(10);
    en <= 1'b0;
    idle(8);
    rchk("qstate", `ADQ_IDX_QUEUE_STATE, 8'h20);
    $display("test trig done");
  endtask

  task automatic t_abort();
    wr(`ADQ_IDX_QUEUE_CTRL, 8'h01);
    wr(`ADQ_IDX_QUEUE_IN, 8'h01);
    wr(`ADQ_IDX_QUEUE_IN, 8'h02);
    seen.delete();
    lat <= 4'h6;
    abort_nxt <= 1'b1;
    en <= 1'b1;
    do @(posedge clk); while (q_abort !== 1'b1);
    abort_nxt <= 1'b0;
    idle(40);
    en <= 1'b0;
    idle(12);
    chk_seen({3'h1, 3'h1, 3'h2, 3'h0}, 3);
    $display("test abort done");
  endtask

  task automatic t_refill();
    wr(`ADQ_IDX_EVENT, 8'h03);
    wr(`ADQ_IDX_ARB_SLOT, 8'h02);
    wr(`ADQ_IDX_QUEUE_IN, 8'h31);
    wr(`ADQ_IDX_QUEUE_IN, 8'h32);
    seen.delete();
    lat <= 4'h1;
    en <= 1'b1;
    idle(10);
    chk("slot off", 8'h00, 8'(seen.size()));
    rchk("qstate", `ADQ_IDX_QUEUE_STATE, 8'h01);
    ns0 = n_svc;
    nd0 = n_done;
    wr(`ADQ_IDX_ARB_SLOT, 8'h03);
    idle(16);
    en <= 1'b0;
    idle(10);
    chk_seen({3'h1, 3'h2, 3'h1, 3'h2}, 4);
    chk("service", 8'(n_done - nd0), 8'(n_svc - ns0));
    rchk("qstate", `ADQ_IDX_QUEUE_STATE, 8'h01);
    rchk("event", `ADQ_IDX_EVENT, 8'h01);
    wr(`ADQ_IDX_EVENT, 8'h01);
    rchk("event", `ADQ_IDX_EVENT, 8'h00);
    $display("test refill done");
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_pend();
    t_scan();
    t_queue();
    t_cmd();
    t_trig();
    t_abort();
    t_refill();
    print_verdict();
  end
endmodule
